// file: rtl/calendar_binary_rtc.sv
// Calendar and binary real-time clock with an AHB-Lite register slave
// Contract
// RULE1 - Control two bit 7 picks calendar or binary
// RULE2 - Calendar counts year to second in BCD
// RULE3 - 12/24 hour select; afternoon flag at bit 6
// RULE4 - Half-minute adjust zeroes seconds, rounds up minutes
// RULE5 - February rollover honours leap years
// RULE6 - Binary mode counts seconds in 32 bits
// RULE7 - Start bit runs and halts counting
// RULE8 - Sub-second counter shows 64 Hz to 1 Hz
// RULE9 - Auto error correction, enable and period bits
// RULE10 - Clock pin 1 Hz or 64 Hz, gated
// RULE11 - Calendar alarm on all enabled fields matching
// RULE12 - Binary alarm compares enabled bits only
// RULE13 - Periodic interrupt, 2 s to 1/256 s
// RULE14 - Carry interrupt, also on read collision
// RULE15 - Alarm or periodic raises wake-up request
// RULE16 - Event edges capture time or counter
// RULE17 - Count source sub-clock or main clock
// RULE18 - Software stops counting before writing time
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
module calendar_binary_rtc
	import rtc_pkg::*;
#(
	parameter int CAP_CH  = 3,
	parameter int SUB_DIV = SUB_DIV_DEF
)
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Oscillator pulses and capture events
	input  wire logic        subClockIn,
	input  wire logic        mainClockIn,
	input  wire logic [CAP_CH-1:0] captureIn,
	// Outputs
	output logic             clockOutPin,
	output logic             irq,
	output logic             wakeRequest,
	output logic             periodicEvent
);
	initial
	begin
		if (CAP_CH < 1 || CAP_CH > 3)
			$error("CAP_CH must be 1 to 3");
	end

	typedef struct packed {
		logic [7:0]          ctl1;
		logic [7:0]          ctl2;
		logic [2*CAP_CH-1:0] capCtl;
		logic [7:0]          adjust;
		logic [7:0]          freq;
		logic                srcSel;
		logic [7:0]          sec;
		logic [7:0]          min;
		logic [7:0]          hour;
		logic [7:0]          wday;
		logic [7:0]          date;
		logic [7:0]          mon;
		logic [15:0]         year;
		logic [7:0]          secAl;
		logic [7:0]          minAl;
		logic [7:0]          hourAl;
		logic [7:0]          wdayAl;
		logic [7:0]          dateAl;
		logic [7:0]          monAl;
		logic [15:0]         yearAl;
		logic [31:0]         bin;
		logic [31:0]         binAl;
		logic [31:0]         binEn;
		logic [ST_W-1:0]     status;
		logic [ST_W-1:0]     irqEn;
		logic                matchPrev;
		logic                twoSec;
		logic [5:0]          corrSecs;
		logic                clkOut;
		logic                perPulse;
		logic                wake;
		logic                irq;
		logic                dWrite;
		logic [7:0]          dAddr;
		logic [31:0]         rdata;
	} rtcState_t;

	rtcState_t st_r;
	rtcState_t st_nxt;
	logic [CAP_CH*CAP_W-1:0] capFlat;
	logic [CAP_W-1:0]        snapshot;

	rtc_tick_if tk ();

	// BCD step with wrap from top to bottom; bit 8 is the wrap
	function automatic logic [8:0] bcdInc(input logic [7:0] v,
		input logic [7:0] top, input logic [7:0] bottom);
		if (v >= top)
			bcdInc = {1'b1, bottom};
		else if (v[3:0] == BCD_NINE)
			bcdInc = {1'b0, v[7:4] + 4'h1, 4'h0};
		else
			bcdInc = {1'b0, v[7:4], v[3:0] + 4'h1};
	endfunction: bcdInc

	// Last date of a month; two-digit BCD year divisible by four
	function automatic logic [7:0] lastDate(input logic [7:0] m,
		input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		if (m == M_FEB)
			lastDate = leap ? D_29 : D_28; // see RULE5
		else if (m == M_APR || m == M_JUN || m == M_SEP || m == M_NOV)
			lastDate = D_30;
		else
			lastDate = D_31;
	endfunction: lastDate

	// Alarm field check, ignored unless its enable bit is set
	function automatic logic fieldHit(input logic [7:0] al,
		input logic [7:0] cnt, input logic [7:0] msk);
		fieldHit = !al[AL_EN] || (((al ^ cnt) & msk) == 8'h00);
	endfunction: fieldHit

	// Periodic hit: carry out of phase bit k-1 is a 2^k/256 s period
	function automatic logic periodHit(input logic [3:0] p,
		input logic [7:0] ph, input logic stp, input logic sc,
		input logic two);
		logic [3:0] k;
		logic [7:0] lowMask;
		k = p - PES_FIRST;
		lowMask = 8'((9'h001 << k) - 9'h001);
		if (p == PES_2S)
			periodHit = sc & two;
		else if (p >= PES_FIRST)
			periodHit = stp & (&(ph | ~lowMask));
		else
			periodHit = 1'b0;
	endfunction: periodHit

	rtc_prescaler #(
		.SUB_DIV     (SUB_DIV)
	) u_prescaler (
		.clk         (clk),
		.arst_n      (arst_n),
		.subClockIn  (subClockIn),
		.mainClockIn (mainClockIn),
		.tk          (tk)
	);

	// Calendar mode latches the date fields, binary mode the counter
	assign snapshot = st_r.ctl2[C2_COUNT_MODE_SELECT]
		? {8'h00, st_r.bin}
		: {st_r.mon, st_r.date, st_r.hour, st_r.min, st_r.sec};

	rtc_capture #(
		.CH       (CAP_CH),
		.W        (CAP_W)
	) u_capture (
		.clk      (clk),
		.arst_n   (arst_n),
		.eventIn  (captureIn),
		.edgeSel  (st_r.capCtl),
		.snapshot (snapshot),
		.capData  (capFlat)
	);

	// Main next-state logic
	always_comb
	begin
		logic        calMode;
		logic        wr;
		logic [31:0] wd;
		logic        adjReq;
		logic        cMin;
		logic        cHour;
		logic        cDay;
		logic        cMon;
		logic        cYr;
		logic [8:0]  inc;
		logic        calHit;
		logic        anyEn;
		logic        match;
		logic        almEv;
		logic        prdEv;
		logic        cupEv;
		logic        accept;
		logic        rdReq;
		logic [31:0] rd;
		logic [5:0]  corrLim;
		int          ch;
		st_nxt = st_r;
		calMode = !st_r.ctl2[C2_COUNT_MODE_SELECT]; // see RULE1
		wr = st_r.dWrite;
		wd = hwdata;
		adjReq = wr && st_r.dAddr == A_CTL2 && wd[C2_HALF_MINUTE_ADJUST] && calMode;
		cMin = 1'b0;
		cHour = 1'b0;
		cDay = 1'b0;
		cMon = 1'b0;
		cYr = 1'b0;
		inc = '0;

		// Prescaler control; stopping freezes the phase as well
		tk.run = st_r.ctl2[C2_START]; // see RULE7
		tk.clear = adjReq;
		tk.adjust = st_r.adjust;
		tk.divisor = st_r.freq;
		tk.srcSel = st_r.srcSel; // see RULE17
		corrLim = st_r.ctl2[C2_AUTO_CORRECT_PERIOD] ? CORR_10S : CORR_MIN;
		tk.corrStart = st_r.ctl2[C2_AUTO_CORRECT_ENABLE] && tk.secCarry
			&& st_r.corrSecs == corrLim; // see RULE9
		if (tk.secCarry)
		begin
			st_nxt.twoSec = !st_r.twoSec;
			st_nxt.corrSecs = (st_r.corrSecs == corrLim)
				? 6'h00 : st_r.corrSecs + 6'h01;
		end

		// Binary seconds count
		if (tk.secCarry && !calMode)
			st_nxt.bin = st_r.bin + 32'h0000_0001; // see RULE6

		// Calendar cascade, one carry per field
		if (tk.secCarry && calMode)
			{cMin, st_nxt.sec} = bcdInc(st_r.sec, SEC_MAX, BCD_ZERO);
		if (adjReq)
		begin
			st_nxt.sec = BCD_ZERO; // see RULE4
			cMin = (st_r.sec >= HALF_MIN); // see RULE4
		end
		if (cMin)
			{cHour, st_nxt.min} = bcdInc(st_r.min, SEC_MAX, BCD_ZERO);
		if (cHour)
		begin
			if (st_r.ctl2[C2_HOUR_FORMAT_SELECT])
				{cDay, st_nxt.hour} = bcdInc({2'b00, st_r.hour[5:0]},
					HOUR_FORMAT_SELECT_MAX, BCD_ZERO); // see RULE3
			else if (st_r.hour[4:0] == HR12_PRE[4:0])
			begin
				// 11 to 12 flips the half day; 11 PM ends the day
				st_nxt.hour = {1'b0, !st_r.hour[HR_PM], HR12_MAX[5:0]};
				cDay = st_r.hour[HR_PM]; // see RULE3
			end
			else
			begin
				inc = bcdInc({3'b000, st_r.hour[4:0]}, HR12_MAX, BCD_ONE);
				st_nxt.hour = {1'b0, st_r.hour[HR_PM], inc[5:0]};
			end
		end
		if (cDay)
		begin
			inc = bcdInc(st_r.wday, WDAY_MAX, BCD_ZERO);
			st_nxt.wday = inc[7:0];
			{cMon, st_nxt.date} = bcdInc(st_r.date,
				lastDate(st_r.mon, st_r.year[7:0]), BCD_ONE); // see RULE2
		end
		if (cMon)
			{cYr, st_nxt.mon} = bcdInc(st_r.mon, MON_MAX, BCD_ONE);
		if (cYr)
		begin
			inc = bcdInc(st_r.year[7:0], YEAR_MAX, BCD_ZERO);
			st_nxt.year[7:0] = inc[7:0];
		end

		// Bus writes win over counting; software halts counting first
		if (wr) // see RULE18
		begin
			case (st_r.dAddr)
				A_SEC:    st_nxt.sec = wd[7:0];
				A_MIN:    st_nxt.min = wd[7:0];
				A_HOUR:   st_nxt.hour = wd[7:0];
				A_WDAY:   st_nxt.wday = wd[7:0];
				A_DATE:   st_nxt.date = wd[7:0];
				A_MON:    st_nxt.mon = wd[7:0];
				A_YEAR:   st_nxt.year = wd[15:0];
				A_SECAL:  st_nxt.secAl = wd[7:0];
				A_MINAL:  st_nxt.minAl = wd[7:0];
				A_HOURAL: st_nxt.hourAl = wd[7:0];
				A_WDAYAL: st_nxt.wdayAl = wd[7:0];
				A_DATEAL: st_nxt.dateAl = wd[7:0];
				A_MONAL:  st_nxt.monAl = wd[7:0];
				A_YEARAL: st_nxt.yearAl = wd[15:0];
				A_CTL1:   st_nxt.ctl1 = wd[7:0];
				A_CTL2:   st_nxt.ctl2 = wd[7:0] & ~(8'h01 << C2_HALF_MINUTE_ADJUST);
				A_CAPCTL: st_nxt.capCtl = wd[2*CAP_CH-1:0];
				A_ADJ:    st_nxt.adjust = wd[7:0];
				A_FREQ:   st_nxt.freq = wd[7:0];
				A_SRC:    st_nxt.srcSel = wd[0];
				A_IRQEN:  st_nxt.irqEn = wd[ST_W-1:0];
				default:
				begin
					// Byte-wide binary groups, lane from address
					if (st_r.dAddr[7:4] == G_BIN)
						st_nxt.bin[8*st_r.dAddr[3:2] +: 8] = wd[7:0];
					else if (st_r.dAddr[7:4] == G_BINAL)
						st_nxt.binAl[8*st_r.dAddr[3:2] +: 8] = wd[7:0];
					else if (st_r.dAddr[7:4] == G_BINEN)
						st_nxt.binEn[8*st_r.dAddr[3:2] +: 8] = wd[7:0];
				end
			endcase
		end

		// Alarm match, acted on at its rising edge only
		calHit = fieldHit(st_r.secAl, st_r.sec, MSK_SEC)
			& fieldHit(st_r.minAl, st_r.min, MSK_SEC)
			& fieldHit(st_r.hourAl, st_r.hour, MSK_SEC)
			& fieldHit(st_r.wdayAl, st_r.wday, MSK_WDAY)
			& fieldHit(st_r.dateAl, st_r.date, MSK_DATE)
			& fieldHit(st_r.monAl, st_r.mon, MSK_MON)
			& (!st_r.yearAl[YAL_EN]
			|| st_r.yearAl[7:0] == st_r.year[7:0]); // see RULE11
		anyEn = st_r.secAl[AL_EN] | st_r.minAl[AL_EN] | st_r.hourAl[AL_EN]
			| st_r.wdayAl[AL_EN] | st_r.dateAl[AL_EN] | st_r.monAl[AL_EN]
			| st_r.yearAl[YAL_EN];
		match = calMode ? (calHit & anyEn)
			: (st_r.binEn != 32'h0
			&& ((st_r.bin ^ st_r.binAl) & st_r.binEn) == 32'h0); // see RULE12
		st_nxt.matchPrev = match;
		almEv = match & !st_r.matchPrev;

		// Periodic tick from the prescaler phase
		prdEv = periodHit(st_r.ctl1[C1_PES +: 4], tk.phase, tk.step,
			tk.secCarry, st_r.twoSec); // see RULE13
		st_nxt.perPulse = prdEv;

		// AHB address phase: whole-word transfers only, single or burst beats
		accept = hsel & htrans[1] & hready & (hsize == HSIZE_WORD);
		st_nxt.dWrite = accept & hwrite;
		st_nxt.dAddr = {haddr[7:2], 2'b00};
		rdReq = accept & !hwrite;

		// Seconds carry, or the 64 Hz digits moving under a read
		cupEv = tk.secCarry | (rdReq && haddr[7:0] == A_SUBSEC
			&& tk.step && tk.phase[0]); // see RULE14

		// Sticky status: a new event beats a same-cycle clear
		if (wr && st_r.dAddr == A_CLR)
			st_nxt.status = st_r.status & ~wd[ST_W-1:0];
		st_nxt.status[ST_ALM] = st_nxt.status[ST_ALM] | almEv;
		st_nxt.status[ST_PRD] = st_nxt.status[ST_PRD] | prdEv;
		st_nxt.status[ST_CUP] = st_nxt.status[ST_CUP] | cupEv;
		st_nxt.irq = |(st_nxt.status & st_nxt.irqEn);
		st_nxt.wake = (st_nxt.status[ST_ALM] & st_nxt.ctl1[C1_AIE])
			| (st_nxt.status[ST_PRD] & st_nxt.ctl1[C1_PIE]); // see RULE15

		// Clock output: phase bit 1 is 64 Hz, bit 7 is 1 Hz
		st_nxt.clkOut = st_r.ctl2[C2_COE]
			& (st_r.ctl1[C1_COS] ? tk.phase[1] : tk.phase[7]); // see RULE10

		// Read mux looks at the updated copy, so a write shows at once
		rd = 32'h0;
		ch = int'(haddr[4:3]);
		case (haddr[7:0])
			A_SUBSEC: rd = {25'h0, tk.phase[7:1]}; // see RULE8
			A_SEC:    rd = {24'h0, st_nxt.sec};
			A_MIN:    rd = {24'h0, st_nxt.min};
			A_HOUR:   rd = {24'h0, st_nxt.hour};
			A_WDAY:   rd = {24'h0, st_nxt.wday};
			A_DATE:   rd = {24'h0, st_nxt.date};
			A_MON:    rd = {24'h0, st_nxt.mon};
			A_YEAR:   rd = {16'h0, st_nxt.year};
			A_SECAL:  rd = {24'h0, st_nxt.secAl};
			A_MINAL:  rd = {24'h0, st_nxt.minAl};
			A_HOURAL: rd = {24'h0, st_nxt.hourAl};
			A_WDAYAL: rd = {24'h0, st_nxt.wdayAl};
			A_DATEAL: rd = {24'h0, st_nxt.dateAl};
			A_MONAL:  rd = {24'h0, st_nxt.monAl};
			A_YEARAL: rd = {16'h0, st_nxt.yearAl};
			A_CTL1:   rd = {24'h0, st_nxt.ctl1};
			A_CTL2:   rd = {24'h0, st_nxt.ctl2};
			A_CAPCTL: rd = 32'(st_nxt.capCtl);
			A_ADJ:    rd = {24'h0, st_nxt.adjust};
			A_FREQ:   rd = {24'h0, st_nxt.freq};
			A_SRC:    rd = {31'h0, st_nxt.srcSel};
			A_STAT:   rd = 32'(st_nxt.status);
			A_IRQEN:  rd = 32'(st_nxt.irqEn);
			default:
			begin
				if (haddr[7:4] == G_BIN)
					rd = {24'h0, st_nxt.bin[8*haddr[3:2] +: 8]};
				else if (haddr[7:4] == G_BINAL)
					rd = {24'h0, st_nxt.binAl[8*haddr[3:2] +: 8]};
				else if (haddr[7:4] == G_BINEN)
					rd = {24'h0, st_nxt.binEn[8*haddr[3:2] +: 8]};
				else if (haddr[7:5] == G_CAP && ch < CAP_CH)
					rd = haddr[2]
						? {24'h0, capFlat[ch*CAP_W+32 +: 8]}
						: capFlat[ch*CAP_W +: 32];
			end
		endcase
		if (rdReq)
			st_nxt.rdata = rd;
	end

	// State register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// Zero-wait slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_r.rdata;
	assign clockOutPin = st_r.clkOut;
	assign irq = st_r.irq;
	assign wakeRequest = st_r.wake;
	assign periodicEvent = st_r.perPulse;
endmodule: calendar_binary_rtc

// file: include/rtc_pkg.sv
// Register map, field positions and BCD limits shared by the RTC files
package rtc_pkg;

	// Register byte offsets, one aligned word each
	localparam logic [7:0] A_SUBSEC = 8'h00;
	localparam logic [7:0] A_SEC    = 8'h04;
	localparam logic [7:0] A_MIN    = 8'h08;
	localparam logic [7:0] A_HOUR   = 8'h0C;
	localparam logic [7:0] A_WDAY   = 8'h10;
	localparam logic [7:0] A_DATE   = 8'h14;
	localparam logic [7:0] A_MON    = 8'h18;
	localparam logic [7:0] A_YEAR   = 8'h1C;
	localparam logic [7:0] A_SECAL  = 8'h20;
	localparam logic [7:0] A_MINAL  = 8'h24;
	localparam logic [7:0] A_HOURAL = 8'h28;
	localparam logic [7:0] A_WDAYAL = 8'h2C;
	localparam logic [7:0] A_DATEAL = 8'h30;
	localparam logic [7:0] A_MONAL  = 8'h34;
	localparam logic [7:0] A_YEARAL = 8'h38;
	localparam logic [7:0] A_CTL1   = 8'h70;
	localparam logic [7:0] A_CTL2   = 8'h74;
	localparam logic [7:0] A_CAPCTL = 8'h78;
	localparam logic [7:0] A_ADJ    = 8'h7C;
	localparam logic [7:0] A_FREQ   = 8'h80;
	localparam logic [7:0] A_SRC    = 8'h84;
	localparam logic [7:0] A_STAT   = 8'h88;
	localparam logic [7:0] A_CLR    = 8'h8C;
	localparam logic [7:0] A_IRQEN  = 8'h90;

	// Groups of four byte registers (lane in address bits 3:2)
	localparam logic [3:0] G_BIN   = 4'h4;
	localparam logic [3:0] G_BINAL = 4'h5;
	localparam logic [3:0] G_BINEN = 4'h6;
	// Capture words at A0 upward: bits 4:3 channel, bit 2 upper byte
	localparam logic [2:0] G_CAP   = 3'h5;

	// Control one fields
	localparam int C1_AIE = 0;
	localparam int C1_PIE = 2;
	localparam int C1_COS = 3;
	localparam int C1_PES = 4;
	// Control two fields
	localparam int C2_START = 0;
	localparam int C2_HALF_MINUTE_ADJUST = 2;
	localparam int C2_COE   = 3;
	localparam int C2_AUTO_CORRECT_ENABLE = 4;
	localparam int C2_AUTO_CORRECT_PERIOD = 5;
	localparam int C2_HOUR_FORMAT_SELECT  = 6;
	localparam int C2_COUNT_MODE_SELECT = 7;
	// Hour afternoon flag, alarm field enables, adjust fields
	localparam int HR_PM    = 6;
	localparam int AL_EN    = 7;
	localparam int YAL_EN   = 15;
	localparam int ADJ_SLOW = 7;
	localparam int ADJ_AMT  = 6;
	// Status bits
	localparam int ST_W   = 3;
	localparam int ST_ALM = 0;
	localparam int ST_PRD = 1;
	localparam int ST_CUP = 2;

	// BCD limits and masks
	localparam logic [7:0] BCD_ZERO = 8'h00;
	localparam logic [7:0] BCD_ONE  = 8'h01;
	localparam logic [3:0] BCD_NINE = 4'h9;
	localparam logic [7:0] SEC_MAX  = 8'h59;
	localparam logic [7:0] HALF_MIN = 8'h30;
	localparam logic [7:0] HOUR_FORMAT_SELECT_MAX = 8'h23;
	localparam logic [7:0] HR12_MAX = 8'h12;
	localparam logic [7:0] HR12_PRE = 8'h11;
	localparam logic [7:0] WDAY_MAX = 8'h06;
	localparam logic [7:0] MON_MAX  = 8'h12;
	localparam logic [7:0] YEAR_MAX = 8'h99;
	localparam logic [7:0] M_FEB    = 8'h02;
	localparam logic [7:0] M_APR    = 8'h04;
	localparam logic [7:0] M_JUN    = 8'h06;
	localparam logic [7:0] M_SEP    = 8'h09;
	localparam logic [7:0] M_NOV    = 8'h11;
	localparam logic [7:0] D_28     = 8'h28;
	localparam logic [7:0] D_29     = 8'h29;
	localparam logic [7:0] D_30     = 8'h30;
	localparam logic [7:0] D_31     = 8'h31;
	localparam logic [7:0] MSK_SEC  = 8'h7F;
	localparam logic [7:0] MSK_WDAY = 8'h07;
	localparam logic [7:0] MSK_DATE = 8'h3F;
	localparam logic [7:0] MSK_MON  = 8'h1F;

	// Periodic select codes, correction spans, bus size
	localparam logic [3:0] PES_FIRST = 4'h6;
	localparam logic [3:0] PES_2S    = 4'hF;
	localparam logic [5:0] CORR_MIN  = 6'h3B;
	localparam logic [5:0] CORR_10S  = 6'h09;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam int SUB_DIV_DEF = 128;
	localparam int CAP_W = 40;

endpackage: rtc_pkg

// file: include/rtc_tick_if.sv
// Prescaler handshake between the RTC core and its tick generator
interface rtc_tick_if;
	logic       run;
	logic       clear;
	logic       corrStart;
	logic [7:0] adjust;
	logic [7:0] divisor;
	logic       srcSel;
	logic       step;
	logic       secCarry;
	logic [7:0] phase;
	modport pre (input run, clear, corrStart, adjust, divisor, srcSel,
		output step, secCarry, phase);
	modport core (output run, clear, corrStart, adjust, divisor, srcSel,
		input step, secCarry, phase);
endinterface: rtc_tick_if

// file: rtl/rtc_prescaler.sv
// 256 Hz prescaler with source select and tick-level error correction
module rtc_prescaler
	import rtc_pkg::*;
#(
	parameter int SUB_DIV = SUB_DIV_DEF
)
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// Oscillator pulses
	input  wire logic subClockIn,
	input  wire logic mainClockIn,
	// Core side
	rtc_tick_if.pre   tk
);
	initial
	begin
		if (SUB_DIV < 2 || SUB_DIV > 256)
			$error("SUB_DIV out of range");
	end

	localparam logic [7:0] SUB_LIMIT = 8'(SUB_DIV - 1);

	typedef struct packed {
		logic [7:0]         div;
		logic [7:0]         phase;
		logic [ADJ_AMT-1:0] owed;
		logic               slow;
	} preState_t;

	preState_t st_r;
	preState_t st_nxt;
	logic      srcTick;
	logic      owedNz;

	// Divide the chosen oscillator, then skip or insert corrective ticks
	always_comb
	begin
		st_nxt = st_r;
		srcTick = 1'b0;
		if (tk.srcSel ? mainClockIn : subClockIn) // see RULE17
		begin
			if (st_r.div >= (tk.srcSel ? tk.divisor : SUB_LIMIT))
			begin
				st_nxt.div = 8'h00;
				srcTick = 1'b1;
			end
			else
				st_nxt.div = st_r.div + 8'h01;
		end
		owedNz = (st_r.owed != '0);
		// Slow: swallow source ticks; fast: add ticks between them
		tk.step = tk.run & (srcTick ? !(owedNz & st_r.slow)
			: (owedNz & !st_r.slow)); // see RULE9
		if (tk.run & owedNz & (st_r.slow ? srcTick : !srcTick))
			st_nxt.owed = st_r.owed - 1'b1;
		if (tk.corrStart)
		begin
			st_nxt.owed = tk.adjust[ADJ_AMT-1:0];
			st_nxt.slow = tk.adjust[ADJ_SLOW];
		end
		if (tk.step)
			st_nxt.phase = st_r.phase + 8'h01;
		tk.secCarry = tk.step & (&st_r.phase) & !tk.clear;
		if (tk.clear)
		begin
			st_nxt.phase = 8'h00;
			st_nxt.div = 8'h00;
		end
	end

	assign tk.phase = st_r.phase;

	// State register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
endmodule: rtc_prescaler

// file: rtl/rtc_capture.sv
// Edge-triggered time capture for a set of event inputs
module rtc_capture
	import rtc_pkg::*;
#(
	parameter int CH = 3,
	parameter int W  = CAP_W
)
(
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            arst_n,
	// Events and per-channel edge select (01 rise, 10 fall, 11 both)
	input  wire logic [CH-1:0]   eventIn,
	input  wire logic [2*CH-1:0] edgeSel,
	// Value to latch and the latched words
	input  wire logic [W-1:0]    snapshot,
	output logic [CH*W-1:0]      capData
);
	initial
	begin
		if (CH < 1 || W < 1)
			$error("capture shape out of range");
	end

	typedef struct packed {
		logic [CH-1:0]        prev;
		logic [CH-1:0][W-1:0] cap;
	} capState_t;

	capState_t st_r;
	capState_t st_nxt;

	// Latch the snapshot on the selected edge of each input
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.prev = eventIn;
		for (int i = 0; i < CH; i++)
		begin
			if ((edgeSel[2*i] & eventIn[i] & !st_r.prev[i])
				| (edgeSel[2*i+1] & !eventIn[i] & st_r.prev[i]))
				st_nxt.cap[i] = snapshot; // see RULE16
		end
	end

	assign capData = st_r.cap;

	// State register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
endmodule: rtc_capture

// file: sim/rtc_properties.sv
// Checker on the RTC top-level ports
module rtc_properties
	import rtc_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        arst_n,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// Outputs
	input wire logic        irq,
	input wire logic        wakeRequest,
	input wire logic        periodicEvent
);
	logic       rd;
	logic [7:0] ra;
	// Read taken now; its data stands after this edge
	assign rd = hsel & htrans[1] & hready & ~hwrite & (hsize == HSIZE_WORD);
	assign ra = haddr[7:0];
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_no_wait:
		assert property (hreadyout) else $error("wait state seen");
	a_resp_okay:
		assert property (!hresp) else $error("error response seen");
	a_unmapped_zero:
		assert property (rd && ra == 8'hFC |=> hrdata == 0)
		else $error("unmapped read not zero");
	a_adjust_self_clear:
		assert property (rd && ra == A_CTL2 |=> !hrdata[C2_HALF_MINUTE_ADJUST])
		else $error("adjust bit reads one");
	a_subsec_width:
		assert property (rd && ra == A_SUBSEC |=> hrdata[31:7] == 0)
		else $error("subsecond read too wide");
	a_sec_bcd:
		assert property (rd && ra == A_SEC
			|=> hrdata[3:0] <= 9 && hrdata[6:4] <= 5)
		else $error("seconds not BCD");
	a_wday_range:
		assert property (rd && ra == A_WDAY |=> hrdata <= 6)
		else $error("weekday out of range");
	a_event_pulse:
		assert property (periodicEvent |=> !periodicEvent)
		else $error("periodic event too long");
	// Main scenarios reached
	c_periodic: cover property (periodicEvent);
	c_irq: cover property ($rose(irq));
	c_wake: cover property ($rose(wakeRequest));
endmodule: rtc_properties

bind calendar_binary_rtc rtc_properties props (.clk, .arst_n, .hsel, .haddr,
	.htrans, .hwrite, .hsize, .hready, .hreadyout, .hresp, .hrdata, .irq,
	.wakeRequest, .periodicEvent);

// file: sim/calendar_binary_rtc_tb_top.sv
// Self-checking bench for the calendar and binary RTC
module calendar_binary_rtc_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import rtc_pkg::*;
	// Bus master and pin drive
	logic        clk = 0, arst_n = 0, hsel = 1, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = HSIZE_WORD;
	logic        subClockIn = 1, mainClockIn = 0;
	logic [2:0]  captureIn = 0;
	// Design outputs and tallies
	logic        hreadyout, hresp, clockOutPin, irq, wakeRequest;
	logic        periodicEvent;
	logic [31:0] hrdata;
	int          mismatches = 0, checksDone = 0, toggles = 0, pulses = 0;

	// Clock; short divider makes a second 512 cycles
	always #12.5 clk = ~clk;
	// Clock-out rises
	always @(posedge clockOutPin) toggles++;
	// Periodic event pulses
	always @(posedge periodicEvent) pulses++;

	calendar_binary_rtc #(.CAP_CH(3), .SUB_DIV(2)) dut (
		.clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .subClockIn,
		.mainClockIn, .captureIn, .clockOutPin, .irq, .wakeRequest,
		.periodicEvent);

	task automatic chk(input string n, input logic [31:0] s, e);
		checksDone++;
		if (s !== e)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask: chk

	// Single word transfer; no wait count is assumed
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask: bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask: wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string n);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(n, r, e);
	endtask: rd

	// Pins sampled mid-cycle, away from the launching edge
	task automatic pin(input string n, ref logic s, input logic e);
		@(negedge clk);
		chk(n, {31'h0, s}, {31'h0, e});
		@(posedge clk);
	endtask: pin

	// Leap day and midnight in 24 h, then a halt
	task automatic t_leap;
		wr(A_CTL2, 32'h40);
		wr(A_YEAR, 32'h24);
		wr(A_MON, 32'h02);
		wr(A_DATE, 32'h28);
		wr(A_HOUR, 32'h23);
		wr(A_MIN, 32'h59);
		wr(A_SEC, 32'h59);
		wr(A_CTL2, 32'h41);
		repeat (600) @(posedge clk);
		wr(A_CTL2, 32'h40);
		rd(A_SEC, 32'h00, "sec");
		rd(A_HOUR, 32'h00, "hour");
		rd(A_WDAY, 32'h01, "wday");
		rd(A_DATE, 32'h29, "date");
		repeat (600) @(posedge clk);
		rd(A_SEC, 32'h00, "halt");
	endtask: t_leap

	// 11 PM rolls to 12 AM and into March; minute alarm and a capture
	task automatic t_12h;
		wr(A_CTL2, 32'h00);
		wr(A_HOUR, 32'h51);
		wr(A_MIN, 32'h59);
		wr(A_MINAL, 32'h80);
		wr(A_SEC, 32'h59);
		wr(A_CTL2, 32'h01);
		repeat (600) @(posedge clk);
		wr(A_CTL2, 32'h00);
		rd(A_HOUR, 32'h12, "hour12");
		rd(A_DATE, 32'h01, "mar1");
		rd(A_MON, 32'h03, "mon");
		rd(A_STAT, 32'h05, "calalm");
		wr(A_CAPCTL, 32'h01);
		// Rise after the enable lands; latched at the next edge
		captureIn <= 3'h1;
		@(posedge clk);
		rd(8'hA0, 32'h0112_0000, "cap");
		rd(8'hA4, 32'h03, "capmon");
	endtask: t_12h

	// Half-minute rounding either side of thirty
	task automatic t_adj;
		logic [7:0] secs[2] = '{8'h45, 8'h29};
		logic [7:0] mins[2] = '{8'h11, 8'h10};
		foreach (secs[i])
		begin
			wr(A_MIN, 32'h10);
			wr(A_SEC, {24'h0, secs[i]});
			wr(A_CTL2, 32'h44);
			// Adjust lands at the same edge as its write; one spare cycle follows
			@(posedge clk);
			rd(A_SEC, 32'h00, "adjsec");
			rd(A_MIN, {24'h0, mins[i]}, "adjmin");
		end
		rd(A_CTL2, 32'h40, "ctl2");
		rd(A_SUBSEC, 32'h00, "subsec");
		rd(8'hFC, 32'h00, "unmapped");
		// Main source with no pulses must leave the prescaler still
		wr(A_SRC, 32'h1);
		wr(A_CTL2, 32'h41);
		repeat (20) @(posedge clk);
		rd(A_SUBSEC, 32'h00, "mainsrc");
		wr(A_CTL2, 32'h40);
		wr(A_SRC, 32'h0);
	endtask: t_adj

	// Binary count into a bit-masked alarm with periodic and clock out
	task automatic t_bin;
		wr(A_CTL2, 32'h80);
		wr(8'h40, 32'hFF);
		wr(8'h54, 32'h01);
		wr(8'h60, 32'hFF);
		wr(8'h64, 32'h01);
		wr(A_IRQEN, 32'h01);
		wr(A_CLR, 32'h07);
		wr(A_CTL1, 32'h69);
		wr(A_CTL2, 32'h89);
		repeat (100) @(posedge clk);
		pin("masked", irq, 1'b0);
		repeat (500) @(posedge clk);
		wr(A_CTL2, 32'h80);
		// Clock pin still shows the old enable for one more edge
		@(posedge clk);
		pin("clkoff", clockOutPin, 1'b0);
		chk("toggles", {31'h0, toggles > 30}, 32'h1);
		chk("pulses", {31'h0, pulses > 200}, 32'h1);
		rd(8'h40, 32'h00, "bin0");
		rd(8'h44, 32'h01, "bin1");
		rd(A_STAT, 32'h07, "stat");
		pin("irq", irq, 1'b1);
		pin("wake", wakeRequest, 1'b1);
		wr(A_CLR, 32'h01);
		rd(A_STAT, 32'h06, "clr");
		pin("irqoff", irq, 1'b0);
	endtask: t_bin

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask: finish_test

	// Reset for three cycles, then the scenarios
	initial
	begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_leap;
		t_12h;
		t_adj;
		t_bin;
		finish_test;
	end

	// Watchdog at about three times the expected run
	initial
	begin
		repeat (8000) @(posedge clk);
		mismatches++;
		finish_test;
	end
endmodule: calendar_binary_rtc_tb_top
